// ### core/isc_combiner.sv
// Contract
// - source bit 16 carries the two-wire serial slave request.
// - source bit 17 carries the pulse-width modulator trip request.
// - source bits 18 and 19 carry external pin interrupts 2 and 3.
// - all 32 enabled status bits are ORed into one core request.
// - raw status bit reads one while its peripheral requests, else zero.
// - raw status bits clear only when the peripheral drops its request.
// - every source has its own enable mask bit.
// - enabled status is raw AND mask; a one requests the core.
// - writing one to the mask enables; writing zero does nothing.
// - writing one to mask clear clears that mask bit only.
`timescale 1ns/1ns
`default_nettype none
module isc_combiner #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // register bus
    input wire isc_pkg::isc_bus_req_t i_bus,
    output logic [isc_pkg::ISC_DW-1:0] o_rdata,
    // interrupt sources
    input wire isc_pkg::isc_named_src_t i_named_src,
    input wire logic [WIDTH-1:0] i_src_misc,
    // requests
    output logic o_irq_req,
    output logic o_evt_irq
);
    import isc_pkg::*;

    // ****************************************
    // source vector
    // ****************************************
    logic [WIDTH-1:0] src_vec;
    logic [WIDTH-1:0] raw_status;

    always_comb begin
        src_vec = i_src_misc;
        src_vec[ISC_BIT_TWI_SLAVE] = i_named_src.twi_slave;
        src_vec[ISC_BIT_PWM_TRIP] = i_named_src.pwm_trip;
        src_vec[ISC_BIT_EXT_PIN_INT_2] = i_named_src.ext_pin_int_2;
        src_vec[ISC_BIT_EXT_PIN_INT_3] = i_named_src.ext_pin_int_3;
    end

    isc_src_sampler #(
        .WIDTH(WIDTH)
    ) u_sampler (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_src(src_vec),
        .o_raw(raw_status)
    );

    // ****************************************
    // address decode
    // ****************************************
    function automatic logic hit(input isc_bus_req_t req, input logic [ISC_AW-1:0] a);
        hit = (req.addr == a);
    endfunction : hit

    function automatic logic [WIDTH-1:0] w1c(input logic [WIDTH-1:0] cur, input logic [WIDTH-1:0] clr,
                                             input logic [WIDTH-1:0] set);
        w1c = (cur & ~clr) | set;
    endfunction : w1c

    logic wr_mask;
    logic wr_clear;
    logic wr_evt_status;
    logic wr_evt_mask;

    always_comb begin
        wr_mask = 1'b0;
        wr_clear = 1'b0;
        wr_evt_status = 1'b0;
        wr_evt_mask = 1'b0;
        if (i_bus.wr && hit(i_bus, ISC_ADDR_ENABLE_MASK)) begin
            wr_mask = 1'b1;
        end else if (i_bus.wr && hit(i_bus, ISC_ADDR_ENABLE_CLEAR)) begin
            wr_clear = 1'b1;
        end else if (i_bus.wr && hit(i_bus, ISC_ADDR_EVT_STATUS)) begin
            wr_evt_status = 1'b1;
        end else if (i_bus.wr && hit(i_bus, ISC_ADDR_EVT_MASK)) begin
            wr_evt_mask = 1'b1;
        end
    end

    // ****************************************
    // enable mask and enabled status
    // ****************************************
    logic [WIDTH-1:0] irq_enable_mask_reg;
    logic [WIDTH-1:0] irq_enable_mask_next;
    logic [WIDTH-1:0] irq_enabled_status;

    always_comb begin
        irq_enable_mask_next = irq_enable_mask_reg;
        if (wr_mask) begin
            irq_enable_mask_next = irq_enable_mask_reg | i_bus.wdata[WIDTH-1:0];
        end else if (wr_clear) begin
            irq_enable_mask_next = irq_enable_mask_reg & ~i_bus.wdata[WIDTH-1:0];
        end
    end

    assign irq_enabled_status = raw_status & irq_enable_mask_reg;

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_enable_mask_reg <= ISC_RST_ENABLE_MASK;
        end else begin
            irq_enable_mask_reg <= irq_enable_mask_next;
        end
    end

    // ****************************************
    // core request
    // ****************************************
    logic irq_req_reg;
    logic irq_req_next;

    always_comb begin
        irq_req_next = |irq_enabled_status;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_req_reg <= 1'b0;
        end else begin
            irq_req_reg <= irq_req_next;
        end
    end

    assign o_irq_req = irq_req_reg;

    // ****************************************
    // sticky events on enabled status rise
    // ****************************************
    logic [WIDTH-1:0] sta_prev_reg;
    logic [WIDTH-1:0] sta_prev_next;
    logic [WIDTH-1:0] evt_status_reg;
    logic [WIDTH-1:0] evt_status_next;
    logic [WIDTH-1:0] evt_mask_reg;
    logic [WIDTH-1:0] evt_mask_next;
    logic [WIDTH-1:0] evt_rise;
    logic evt_irq_reg;
    logic evt_irq_next;

    always_comb begin
        evt_rise = irq_enabled_status & ~sta_prev_reg;
        sta_prev_next = irq_enabled_status;
        // set wins over write-one-clear
        evt_status_next = w1c(evt_status_reg, wr_evt_status ? i_bus.wdata[WIDTH-1:0] : '0, evt_rise);
        evt_mask_next = wr_evt_mask ? i_bus.wdata[WIDTH-1:0] : evt_mask_reg;
        evt_irq_next = |(evt_status_next & evt_mask_next);
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sta_prev_reg <= '0;
            evt_status_reg <= '0;
            evt_mask_reg <= ISC_RST_EVT_MASK;
            evt_irq_reg <= 1'b0;
        end else begin
            sta_prev_reg <= sta_prev_next;
            evt_status_reg <= evt_status_next;
            evt_mask_reg <= evt_mask_next;
            evt_irq_reg <= evt_irq_next;
        end
    end

    assign o_evt_irq = evt_irq_reg;

    // ****************************************
    // read path
    // ****************************************
    logic [ISC_DW-1:0] rdata_reg;
    logic [ISC_DW-1:0] rdata_next;

    always_comb begin
        rdata_next = ISC_RST_ZERO;
        if (!i_bus.rd) begin
            rdata_next = ISC_RST_ZERO;
        end else if (hit(i_bus, ISC_ADDR_ENABLED_STATUS)) begin
            rdata_next = ISC_DW'(irq_enabled_status);
        end else if (hit(i_bus, ISC_ADDR_RAW_STATUS)) begin
            rdata_next = ISC_DW'(raw_status);
        end else if (hit(i_bus, ISC_ADDR_ENABLE_MASK)) begin
            rdata_next = ISC_DW'(irq_enable_mask_reg);
        end else if (hit(i_bus, ISC_ADDR_EVT_STATUS)) begin
            rdata_next = ISC_DW'(evt_status_reg);
        end else if (hit(i_bus, ISC_ADDR_EVT_MASK)) begin
            rdata_next = ISC_DW'(evt_mask_reg);
        end else begin
            rdata_next = ISC_RD_UNMAPPED;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_reg <= ISC_RST_ZERO;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign o_rdata = rdata_reg;

    // ****************************************
    // assertions
    // ****************************************
    property p_twi_pos;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        i_named_src.twi_slave |=> raw_status[ISC_BIT_TWI_SLAVE];
    endproperty
    a_twi_pos: assert property (p_twi_pos) else $error("slave request not at bit 16");

    property p_pwm_pos;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        i_named_src.pwm_trip |=> raw_status[ISC_BIT_PWM_TRIP];
    endproperty
    a_pwm_pos: assert property (p_pwm_pos) else $error("trip request not at bit 17");

    property p_pin_pos;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        1'b1 |=> raw_status[ISC_BIT_EXT_PIN_INT_2] == $past(i_named_src.ext_pin_int_2)
            && raw_status[ISC_BIT_EXT_PIN_INT_3] == $past(i_named_src.ext_pin_int_3);
    endproperty
    a_pin_pos: assert property (p_pin_pos) else $error("pin interrupts not at bits 18 and 19");

    property p_or_req;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        ((|(src_vec & irq_enable_mask_next)) ##1 1'b1) |=> o_irq_req;
    endproperty
    a_or_req: assert property (p_or_req) else $error("enabled source did not raise request in two cycles");

    property p_no_req;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        !(|irq_enabled_status) |=> !o_irq_req;
    endproperty
    a_no_req: assert property (p_no_req) else $error("request without enabled source");

    property p_raw_level;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        1'b1 |=> raw_status == $past(src_vec);
    endproperty
    a_raw_level: assert property (p_raw_level) else $error("raw status differs from source levels");

    property p_raw_hold;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_named_src.pwm_trip [*2]) |-> raw_status[ISC_BIT_PWM_TRIP];
    endproperty
    a_raw_hold: assert property (p_raw_hold) else $error("raw bit cleared while source requests");

    property p_sta_read;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_bus.rd && i_bus.addr == ISC_ADDR_ENABLED_STATUS) |=>
            o_rdata == ISC_DW'($past(raw_status) & $past(irq_enable_mask_reg));
    endproperty
    a_sta_read: assert property (p_sta_read) else $error("enabled status read is not raw and mask");

    property p_mask_gate;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (irq_enable_mask_reg == '0) |=> !o_irq_req;
    endproperty
    a_mask_gate: assert property (p_mask_gate) else $error("masked sources raised request");

    property p_mask_zero_write;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_bus.wr && i_bus.addr == ISC_ADDR_ENABLE_MASK) |=>
            irq_enable_mask_reg == ($past(irq_enable_mask_reg) | $past(i_bus.wdata[WIDTH-1:0]));
    endproperty
    a_mask_zero_write: assert property (p_mask_zero_write) else $error("mask write cleared a bit");

    property p_clear;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_bus.wr && i_bus.addr == ISC_ADDR_ENABLE_CLEAR) |=>
            irq_enable_mask_reg == ($past(irq_enable_mask_reg) & ~$past(i_bus.wdata[WIDTH-1:0]));
    endproperty
    a_clear: assert property (p_clear) else $error("mask clear wrong");

    property p_raw_write;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_bus.wr && i_bus.addr == ISC_ADDR_RAW_STATUS) |=>
            $stable(irq_enable_mask_reg) && $stable(evt_mask_reg) && raw_status == $past(src_vec);
    endproperty
    a_raw_write: assert property (p_raw_write) else $error("raw status write disturbed state");

    property p_evt_set_wins;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (|evt_rise) |=> ((evt_status_reg & $past(evt_rise)) == $past(evt_rise));
    endproperty
    a_evt_set_wins: assert property (p_evt_set_wins) else $error("event lost");

    c_req: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) $rose(o_irq_req));
    c_clear_drop: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_bus.wr && i_bus.addr == ISC_ADDR_ENABLE_CLEAR && o_irq_req) ##2 !o_irq_req);
    c_evt: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) $rose(o_evt_irq));
    c_raw_write: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_bus.wr && i_bus.addr == ISC_ADDR_RAW_STATUS);

endmodule : isc_combiner
`default_nettype wire

// ### core/isc_pkg.sv
`default_nettype none
package isc_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int ISC_DW = 32;
    localparam int ISC_AW = 32;

    // ****************************************
    // register byte addresses
    // ****************************************
    localparam logic [ISC_AW-1:0] ISC_ADDR_ENABLED_STATUS = 32'hFFFF0000;
    localparam logic [ISC_AW-1:0] ISC_ADDR_RAW_STATUS = 32'hFFFF0004;
    localparam logic [ISC_AW-1:0] ISC_ADDR_ENABLE_MASK = 32'hFFFF0008;
    localparam logic [ISC_AW-1:0] ISC_ADDR_ENABLE_CLEAR = 32'hFFFF000C;
    localparam logic [ISC_AW-1:0] ISC_ADDR_EVT_STATUS = 32'hFFFF0020;
    localparam logic [ISC_AW-1:0] ISC_ADDR_EVT_MASK = 32'hFFFF0024;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [ISC_DW-1:0] ISC_RST_ZERO = 32'h00000000;
    localparam logic [ISC_DW-1:0] ISC_RST_ENABLE_MASK = 32'h00000000;
    localparam logic [ISC_DW-1:0] ISC_RST_EVT_MASK = 32'h00000000;
    localparam logic [ISC_DW-1:0] ISC_RD_UNMAPPED = 32'h00000000;

    // ****************************************
    // source bit positions
    // ****************************************
    localparam int ISC_BIT_TWI_SLAVE = 16;
    localparam int ISC_BIT_PWM_TRIP = 17;
    localparam int ISC_BIT_EXT_PIN_INT_2 = 18;
    localparam int ISC_BIT_EXT_PIN_INT_3 = 19;

    // ****************************************
    // register bus request
    // ****************************************
    typedef struct packed {
        logic [ISC_AW-1:0] addr;
        logic [ISC_DW-1:0] wdata;
        logic wr;
        logic rd;
    } isc_bus_req_t;

    // named sources that own fixed positions
    typedef struct packed {
        logic twi_slave;
        logic pwm_trip;
        logic ext_pin_int_2;
        logic ext_pin_int_3;
    } isc_named_src_t;

endpackage : isc_pkg
`default_nettype wire

// ### core/isc_src_sampler.sv
`timescale 1ns/1ns
`default_nettype none
module isc_src_sampler #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // source levels
    input wire logic [WIDTH-1:0] i_src,
    // registered raw status
    output logic [WIDTH-1:0] o_raw
);
    import isc_pkg::*;

    logic [WIDTH-1:0] raw_reg;
    logic [WIDTH-1:0] raw_next;

    // raw follows the peripheral level only; no bus path reaches it
    // clears with source
    always_comb begin
        raw_next = i_src;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            raw_reg <= '0;
        end else begin
            raw_reg <= raw_next;
        end
    end

    assign o_raw = raw_reg;

endmodule : isc_src_sampler
`default_nettype wire

// ### verif/isc_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module isc_core_model (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // combined request from the controller
    input wire logic i_irq,
    // exception entries taken
    output logic [7:0] o_irq_count
);
    logic irq_d;

    // one request line
    // each rise of the level request is taken as one exception entry
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_d <= 1'b0;
            o_irq_count <= 8'h00;
        end else begin
            irq_d <= i_irq;
            if (i_irq && !irq_d) begin
                o_irq_count <= o_irq_count + 8'h01;
            end
        end
    end
endmodule : isc_core_model
`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import isc_pkg::*;
    logic i_clk_sys;
    logic i_rst_b;
    isc_bus_req_t bus;
    logic [ISC_DW-1:0] rdata;
    isc_named_src_t named;
    logic [31:0] misc;
    logic irq_req;
    logic evt_irq;
    logic [7:0] irq_count;
    int failures;
    int n_tests;

    isc_combiner #(.WIDTH(32)) u_dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_bus(bus), .o_rdata(rdata),
        .i_named_src(named), .i_src_misc(misc), .o_irq_req(irq_req), .o_evt_irq(evt_irq));
    isc_core_model u_core (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_irq(irq_req), .o_irq_count(irq_count));

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, seen);
            failures++;
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask : tick

    task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge i_clk_sys);
        bus.wr <= 1'b0;
    endtask : bus_wr

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string name);
        @(posedge i_clk_sys);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge i_clk_sys);
        bus.rd <= 1'b0;
        #1;
        check(name, rdata, exp);
    endtask : rd_chk

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        rd_chk(ISC_ADDR_ENABLED_STATUS, ISC_RST_ZERO, "enabled status reset");
        rd_chk(ISC_ADDR_RAW_STATUS, ISC_RST_ZERO, "raw status reset");
        rd_chk(ISC_ADDR_ENABLE_MASK, ISC_RST_ENABLE_MASK, "enable mask reset");
        rd_chk(ISC_ADDR_EVT_MASK, ISC_RST_EVT_MASK, "event mask reset");
        rd_chk(32'hFFFF0030, ISC_RD_UNMAPPED, "unmapped read");
        @(posedge i_clk_sys);
        #1;
        check("read data after one cycle", rdata, 32'h00000000);
        check("request after reset", irq_req, 1'b0);
    endtask : t_reset

    task automatic t_named;
        bus_wr(ISC_ADDR_ENABLE_MASK, 32'hFFFFFFFF);
        misc <= 32'h000F0000;
        tick(3);
        #1;
        check("misc bits 16..19 ignored", irq_req, 1'b0);
        for (int i = 0; i < 4; i++) begin
            named <= isc_named_src_t'(4'h8 >> i);
            tick(3);
            rd_chk(ISC_ADDR_RAW_STATUS, 32'h00000001 << (16 + i), "named source position");
            check("named source request", irq_req, 1'b1);
        end
        named <= isc_named_src_t'(4'h0);
        misc <= 32'h00000000;
        bus_wr(ISC_ADDR_ENABLE_CLEAR, 32'hFFFFFFFF);
    endtask : t_named

    task automatic t_mask;
        bus_wr(ISC_ADDR_ENABLE_MASK, 32'h000000F0);
        bus_wr(ISC_ADDR_ENABLE_MASK, 32'h00000000);
        rd_chk(ISC_ADDR_ENABLE_MASK, 32'h000000F0, "mask zero write");
        bus_wr(ISC_ADDR_ENABLE_MASK, 32'h00000003);
        rd_chk(ISC_ADDR_ENABLE_MASK, 32'h000000F3, "mask set only");
        bus_wr(ISC_ADDR_ENABLE_CLEAR, 32'h00000030);
        rd_chk(ISC_ADDR_ENABLE_MASK, 32'h000000C3, "mask clear");
        rd_chk(ISC_ADDR_ENABLE_CLEAR, 32'h00000000, "clear reads zero");
    endtask : t_mask

    task automatic t_enabled;
        logic [7:0] cnt;
        misc <= 32'h000000A5;
        tick(3);
        rd_chk(ISC_ADDR_RAW_STATUS, 32'h000000A5, "raw follows sources");
        rd_chk(ISC_ADDR_ENABLED_STATUS, 32'h00000081, "raw and mask");
        check("enabled request", irq_req, 1'b1);
        for (int b = 0; b < 32; b += 31) begin
            misc <= 32'h00000000;
            bus_wr(ISC_ADDR_ENABLE_CLEAR, 32'hFFFFFFFF);
            tick(3);
            #1;
            check("request idle", irq_req, 1'b0);
            misc <= 32'h00000001 << b;
            tick(3);
            #1;
            check("masked source", irq_req, 1'b0);
            cnt = irq_count;
            bus_wr(ISC_ADDR_ENABLE_MASK, 32'h00000001 << b);
            tick(2);
            // the core model counts one edge after the edge that raises the request
            #1;
            check("unmasked source", irq_req, 1'b1);
            check("core entries", irq_count, cnt + 8'h01);
        end
        misc <= 32'h00000000;
        bus_wr(ISC_ADDR_ENABLE_CLEAR, 32'hFFFFFFFF);
    endtask : t_enabled

    task automatic t_raw_write;
        misc <= 32'h00000100;
        bus_wr(ISC_ADDR_ENABLE_MASK, 32'h00000100);
        tick(3);
        bus_wr(ISC_ADDR_RAW_STATUS, 32'h00000000);
        bus_wr(ISC_ADDR_ENABLED_STATUS, 32'h00000000);
        rd_chk(ISC_ADDR_RAW_STATUS, 32'h00000100, "raw after write");
        rd_chk(ISC_ADDR_ENABLE_MASK, 32'h00000100, "mask after raw write");
        check("request after raw write", irq_req, 1'b1);
        misc <= 32'h00000000;
        tick(3);
        rd_chk(ISC_ADDR_RAW_STATUS, 32'h00000000, "raw after source drop");
        check("request after source drop", irq_req, 1'b0);
        bus_wr(ISC_ADDR_ENABLE_CLEAR, 32'hFFFFFFFF);
    endtask : t_raw_write

    task automatic t_event;
        bus_wr(ISC_ADDR_EVT_STATUS, 32'hFFFFFFFF);
        bus_wr(ISC_ADDR_ENABLE_MASK, 32'h00000200);
        misc <= 32'h00000200;
        tick(3);
        rd_chk(ISC_ADDR_EVT_STATUS, 32'h00000200, "event status set");
        check("event masked", evt_irq, 1'b0);
        bus_wr(ISC_ADDR_EVT_MASK, 32'h00000200);
        tick(1);
        #1;
        check("event unmasked", evt_irq, 1'b1);
        misc <= 32'h00000000;
        tick(3);
        #1;
        check("event sticky", evt_irq, 1'b1);
        bus_wr(ISC_ADDR_EVT_STATUS, 32'h00000200);
        tick(1);
        rd_chk(ISC_ADDR_EVT_STATUS, 32'h00000000, "event cleared");
        check("event after clear", evt_irq, 1'b0);
        rd_chk(ISC_ADDR_EVT_MASK, 32'h00000200, "event mask readback");
    endtask : t_event

    // ****************************************
    // run
    // ****************************************
    initial begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end

    initial begin
        repeat (5000) @(posedge i_clk_sys);
        failures++;
        report_and_stop();
    end

    initial begin
        failures = 0;
        n_tests = 0;
        i_rst_b = 1'b0;
        bus = '0;
        named = isc_named_src_t'(4'h0);
        misc = 32'h00000000;
        tick(10);
        i_rst_b <= 1'b1;
        t_reset();
        t_named();
        t_mask();
        t_enabled();
        t_raw_write();
        t_event();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
